// ### hdl/ccg_map.svh
// Register map and timing counts of the CPU clock generator
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

`define CCG_CLK_SEL_ADDR 16'hfffb
`define CCG_CLK_SEL_RESET 8'h02
`define CCG_SPEED_BIT 1
`define CCG_SW_FAST_TO_SLOW 3'h4
`define CCG_SW_SLOW_TO_FAST 3'h2
`define CCG_QUARTER_LAST 2'h3
`define CCG_STAB_LOG2_RC 7
`define CCG_STAB_LOG2_XTAL 15
`define CCG_PTAP_N 6

`endif

// ### hdl/ccg_pkg.sv
// Types shared by the CPU clock generator files
package ccg_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic bit_wr;
        logic [2:0] bit_pos;
        logic [7:0] wdata;
    } ccg_bus_req_t;

    typedef enum logic [4:0] {
        CCG_ST_BOOT = 5'h01,
        CCG_ST_RUN = 5'h02,
        CCG_ST_HALT = 5'h04,
        CCG_ST_STOP = 5'h08,
        CCG_ST_WAKE = 5'h10
    } ccg_state_t;

endpackage

// ### hdl/ccg_clk_div.sv
// Divider chain: CPU clock enable and peripheral clock enables
`timescale 1ns/1ps
`include "ccg_map.svh"

module ccg_clk_div (
    input wire logic mclk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic run, // Oscillator running
    input wire logic cpu_en, // CPU clock allowed
    input wire logic speed, // 1: divide by four
    output logic cpu_tick, // One CPU clock period ends
    output logic [`CCG_PTAP_N-1:0] periph_tick // Tap i: system clock / 2^(i+1)
);

    logic [1:0] cpu_cnt_q;
    logic [1:0] cpu_cnt_d;
    logic [`CCG_PTAP_N-1:0] div_q;
    logic [`CCG_PTAP_N-1:0] div_d;

    // Phase restarts at every tick, so a new ratio never gives a short period
    assign cpu_tick = cpu_en && (!speed || cpu_cnt_q == `CCG_QUARTER_LAST);
    assign cpu_cnt_d = (!cpu_en || cpu_tick) ? 2'h0 : cpu_cnt_q + 2'h1;
    assign div_d = run ? div_q + {{(`CCG_PTAP_N-1){1'b0}}, 1'b1} : div_q;

    genvar gi;
    generate
        for (gi = 0; gi < `CCG_PTAP_N; gi++) begin : g_tap
            assign periph_tick[gi] = run && (&div_q[gi:0]);
        end
    endgenerate

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cpu_cnt_q <= 2'h0;
            div_q <= '0;
        end else begin
            cpu_cnt_q <= cpu_cnt_d;
            div_q <= div_d;
        end
    end

endmodule // ccg_clk_div

// ### hdl/ccg_top.sv
// CPU clock generator: speed select register, switch-over, start-up and standby
// Summary of operation
// - Bit 1 of the clock select register picks full speed at 0 and the clock over four at 1.
// - Reset loads the clock select register with 02h so the CPU starts slow.
// - One shortest instruction lasts two periods of the selected CPU clock.
// - After the speed bit changes, the old clock keeps running for a few instructions.
// - Switch-over takes at most 4 clocks going slow and at most 2 clocks going fast.
// - Switch-over clocks are counted in periods of the CPU clock in effect before it.
// - While reset is held the CPU stays in reset and the oscillator is stopped.
// - After reset the oscillator starts and 2^7 periods pass (2^15 for crystal) before the CPU runs.
// - After that wait the CPU runs at the slow speed given by the reset value.
// - The stop instruction halts the oscillator.
// - Two standby modes exist, stop and halt, both controlled here.
// - Peripheral clocks come from dividing the system clock and stop when it stops.
// - The clock select register takes both single-bit and byte accesses.
`timescale 1ns/1ps
`include "ccg_map.svh"

module ccg_top #(
    parameter int STAB_LOG2 = `CCG_STAB_LOG2_RC // Use CCG_STAB_LOG2_XTAL for crystal
) (
    input wire logic mclk, // System clock, 250 MHz
    input wire logic reset, // Async reset, active high
    input ccg_pkg::ccg_bus_req_t bus_req, // CPU register access
    input wire logic stop_req, // CPU executes stop, one-cycle pulse
    input wire logic halt_req, // CPU executes halt, one-cycle pulse
    input wire logic wake, // Standby release request
    output logic [7:0] rdata_q, // Read data, one cycle after rd
    output logic cpu_reset_q, // CPU held in reset
    output logic osc_run_q, // Oscillator running
    output logic cpu_tick_q, // CPU clock enable pulse
    output logic instr_tick_q, // Shortest instruction boundary
    output logic cpu_speed_q, // Clock in effect, 1: divided by four
    output logic [`CCG_PTAP_N-1:0] periph_tick_q, // Peripheral clock enables
    output logic [1:0] standby_q // Bit 1: stop, bit 0: halt
);

    localparam logic [15:0] STAB_LAST = 16'((32'd1 << STAB_LOG2) - 32'd1);

    ccg_pkg::ccg_state_t state_q;
    ccg_pkg::ccg_state_t state_d;
    logic [7:0] clk_sel_q;
    logic [7:0] clk_sel_d;
    logic [15:0] stab_cnt_q;
    logic [15:0] stab_cnt_d;
    logic [2:0] sw_cnt_q;
    logic [2:0] sw_cnt_d;
    logic half_q;
    logic cpu_speed_d;
    logic cpu_tick;
    logic [`CCG_PTAP_N-1:0] periph_tick;

    // Register decode
    wire addr_hit = bus_req.addr == `CCG_CLK_SEL_ADDR;
    wire byte_wr = addr_hit && bus_req.wr;
    wire bit_wr = addr_hit && bus_req.bit_wr;
    wire rd_hit = addr_hit && bus_req.rd;
    wire [7:0] rdata_d = rd_hit ? clk_sel_q : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sel_bit
            assign clk_sel_d[gi] = byte_wr ? bus_req.wdata[gi] :
                (bit_wr && bus_req.bit_pos == 3'(gi)) ? bus_req.wdata[0] :
                clk_sel_q[gi];
        end
    endgenerate

    wire speed_sel = clk_sel_q[`CCG_SPEED_BIT];
    wire st_boot = state_q == ccg_pkg::CCG_ST_BOOT;
    wire st_run = state_q == ccg_pkg::CCG_ST_RUN;
    wire st_wake = state_q == ccg_pkg::CCG_ST_WAKE;
    wire stab_done = stab_cnt_q == STAB_LAST;

    // Oscillator wait after reset or stop
    assign stab_cnt_d = (st_boot || st_wake) && !stab_done ? stab_cnt_q + 16'h0001 : 16'h0000;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ccg_pkg::CCG_ST_BOOT: if (stab_done) state_d = ccg_pkg::CCG_ST_RUN;
            ccg_pkg::CCG_ST_RUN: begin
                if (stop_req) begin
                    state_d = ccg_pkg::CCG_ST_STOP;
                end else if (halt_req) begin
                    state_d = ccg_pkg::CCG_ST_HALT;
                end
            end
            ccg_pkg::CCG_ST_HALT: if (wake) state_d = ccg_pkg::CCG_ST_RUN;
            ccg_pkg::CCG_ST_STOP: if (wake) state_d = ccg_pkg::CCG_ST_WAKE;
            ccg_pkg::CCG_ST_WAKE: if (stab_done) state_d = ccg_pkg::CCG_ST_RUN;
            default: state_d = ccg_pkg::CCG_ST_BOOT;
        endcase
    end

    // Old clock stays in effect for a fixed number of its own periods
    wire sw_pending = speed_sel != cpu_speed_q;
    // A tick in the load cycle is already one old period
    wire [2:0] sw_load = (cpu_speed_q ? `CCG_SW_SLOW_TO_FAST : `CCG_SW_FAST_TO_SLOW)
        - (cpu_tick ? 3'h1 : 3'h0);
    assign sw_cnt_d = !sw_pending ? 3'h0 :
        (sw_cnt_q == 3'h0) ? sw_load :
        cpu_tick ? sw_cnt_q - 3'h1 : sw_cnt_q;
    // Swap only on a CPU period boundary
    assign cpu_speed_d = (sw_pending && sw_cnt_q == 3'h1 && cpu_tick) ? speed_sel : cpu_speed_q;

    ccg_clk_div u_div (
        .mclk(mclk),
        .reset(reset),
        .run(osc_run_q),
        .cpu_en(st_run),
        .speed(cpu_speed_q),
        .cpu_tick(cpu_tick),
        .periph_tick(periph_tick)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ccg_pkg::CCG_ST_BOOT;
            clk_sel_q <= `CCG_CLK_SEL_RESET;
            stab_cnt_q <= 16'h0000;
            sw_cnt_q <= 3'h0;
            cpu_speed_q <= 1'b1;
            half_q <= 1'b0;
            rdata_q <= 8'h00;
            cpu_reset_q <= 1'b1;
            osc_run_q <= 1'b0;
            cpu_tick_q <= 1'b0;
            instr_tick_q <= 1'b0;
            periph_tick_q <= '0;
            standby_q <= 2'h0;
        end else begin
            state_q <= state_d;
            clk_sel_q <= clk_sel_d;
            stab_cnt_q <= stab_cnt_d;
            sw_cnt_q <= sw_cnt_d;
            cpu_speed_q <= cpu_speed_d;
            half_q <= cpu_tick ? !half_q : half_q;
            rdata_q <= rdata_d;
            cpu_reset_q <= state_d == ccg_pkg::CCG_ST_BOOT;
            osc_run_q <= state_d != ccg_pkg::CCG_ST_STOP;
            cpu_tick_q <= cpu_tick;
            instr_tick_q <= cpu_tick && half_q;
            periph_tick_q <= periph_tick;
            standby_q <= {state_d == ccg_pkg::CCG_ST_STOP, state_d == ccg_pkg::CCG_ST_HALT};
        end
    end

    // Checks
    sequence s_fast_to_slow;
        st_run && speed_sel && !cpu_speed_q && sw_cnt_q == 3'h0;
    endsequence

    sequence s_slow_to_fast;
        st_run && !speed_sel && cpu_speed_q && sw_cnt_q == 3'h0;
    endsequence

    property p_reset_load;
        @(posedge mclk) disable iff (reset)
        $past(reset) |-> clk_sel_q == `CCG_CLK_SEL_RESET && cpu_speed_q;
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("select register not 02h after reset");

    property p_full_speed;
        @(posedge mclk) disable iff (reset)
        st_run && !cpu_speed_q |=> cpu_tick_q;
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("full speed tick missing");

    property p_quarter_period;
        @(posedge mclk) disable iff (reset)
        cpu_tick_q && cpu_speed_q |=> !cpu_tick_q [*3];
    endproperty
    a_quarter_period: assert property (p_quarter_period) else $error("short divided period");

    property p_instr_two;
        @(posedge mclk) disable iff (reset)
        instr_tick_q |-> cpu_tick_q && !$past(instr_tick_q);
    endproperty
    a_instr_two: assert property (p_instr_two) else $error("instruction not two CPU clocks");

    property p_sw_slow;
        @(posedge mclk) disable iff (reset)
        s_fast_to_slow ##1 (st_run && speed_sel) [*3] |=> cpu_speed_q;
    endproperty
    a_sw_slow: assert property (p_sw_slow) else $error("switch to slow over 4 clocks");

    property p_sw_fast;
        @(posedge mclk) disable iff (reset)
        s_slow_to_fast ##1 (st_run && !speed_sel) [*7] |=> !cpu_speed_q;
    endproperty
    a_sw_fast: assert property (p_sw_fast) else $error("switch to fast over 2 clocks");

    property p_sw_boundary;
        @(posedge mclk) disable iff (reset)
        $changed(cpu_speed_q) |-> $past(cpu_tick) && $past(sw_cnt_q) == 3'h1;
    endproperty
    a_sw_boundary: assert property (p_sw_boundary) else $error("speed changed off boundary");

    property p_boot_wait;
        @(posedge mclk) disable iff (reset)
        $fell(cpu_reset_q) |-> $past(st_boot) && $past(stab_cnt_q) == STAB_LAST && cpu_speed_q;
    endproperty
    a_boot_wait: assert property (p_boot_wait) else $error("CPU released early or fast");

    property p_held_reset;
        @(posedge mclk) disable iff (reset)
        $past(reset) |-> cpu_reset_q && !cpu_tick_q;
    endproperty
    a_held_reset: assert property (p_held_reset) else $error("CPU free right after reset");

    property p_stop_osc;
        @(posedge mclk) disable iff (reset)
        st_run && stop_req |=> !osc_run_q && standby_q == 2'h2 ##1 !cpu_tick_q;
    endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("stop left oscillator on");

    property p_halt;
        @(posedge mclk) disable iff (reset)
        st_run && halt_req && !stop_req |=> osc_run_q && standby_q == 2'h1 ##1 !cpu_tick_q;
    endproperty
    a_halt: assert property (p_halt) else $error("halt mode wrong");

    property p_periph_stop;
        @(posedge mclk) disable iff (reset)
        !osc_run_q |=> periph_tick_q == '0;
    endproperty
    a_periph_stop: assert property (p_periph_stop) else $error("peripheral clock without oscillator");

    property p_bit_write;
        @(posedge mclk) disable iff (reset)
        bit_wr && !byte_wr |=> clk_sel_q[$past(bus_req.bit_pos)] == $past(bus_req.wdata[0]);
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write not stored");

    property p_boot_osc;
        @(posedge mclk) disable iff (reset)
        st_boot |=> osc_run_q;
    endproperty
    a_boot_osc: assert property (p_boot_osc) else $error("osc idle in start-up wait");

    property p_boot_hold;
        @(posedge mclk) disable iff (reset)
        st_boot |-> cpu_reset_q && !cpu_tick_q && standby_q == 2'h0;
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("CPU free in start-up wait");

    property p_run_free;
        @(posedge mclk) disable iff (reset)
        st_run |-> !cpu_reset_q;
    endproperty
    a_run_free: assert property (p_run_free) else $error("CPU held in reset while running");

    property p_wake_osc;
        @(posedge mclk) disable iff (reset)
        st_wake |=> osc_run_q && !cpu_tick_q;
    endproperty
    a_wake_osc: assert property (p_wake_osc) else $error("wake wait wrong");

    property p_wake_count;
        @(posedge mclk) disable iff (reset)
        st_wake && !stab_done |=> st_wake && stab_cnt_q == $past(stab_cnt_q) + 16'h0001;
    endproperty
    a_wake_count: assert property (p_wake_count) else $error("wake wait cut short");

    property p_wake_done;
        @(posedge mclk) disable iff (reset)
        st_wake && stab_done |=> st_run && !cpu_reset_q;
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("no run after wake wait");

    property p_stop_hold;
        @(posedge mclk) disable iff (reset)
        state_q == ccg_pkg::CCG_ST_STOP && !wake |=> !osc_run_q && standby_q == 2'h2;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop mode left");

    property p_halt_wake;
        @(posedge mclk) disable iff (reset)
        state_q == ccg_pkg::CCG_ST_HALT && wake |=> st_run && osc_run_q && standby_q == 2'h0;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt release wrong");

    property p_tick_gate;
        @(posedge mclk) disable iff (reset)
        !st_run |=> !cpu_tick_q && !instr_tick_q;
    endproperty
    a_tick_gate: assert property (p_tick_gate) else $error("CPU tick outside run");

    property p_read_back;
        @(posedge mclk) disable iff (reset)
        rd_hit |=> rdata_q == $past(clk_sel_q);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong");

    property p_read_idle;
        @(posedge mclk) disable iff (reset)
        !rd_hit |=> rdata_q == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without read");

    property p_byte_write;
        @(posedge mclk) disable iff (reset)
        byte_wr |=> clk_sel_q == $past(bus_req.wdata);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("byte write not stored");

    property p_no_write;
        @(posedge mclk) disable iff (reset)
        !byte_wr && !bit_wr |=> $stable(clk_sel_q);
    endproperty
    a_no_write: assert property (p_no_write) else $error("register changed unwritten");

    property p_speed_hold;
        @(posedge mclk) disable iff (reset)
        !sw_pending |=> $stable(cpu_speed_q);
    endproperty
    a_speed_hold: assert property (p_speed_hold) else $error("speed changed unasked");

endmodule // ccg_top

// ### test/ccg_cpu_model.sv
// Behavioural CPU side: measures spacing of the clock enables it consumes
`timescale 1ns/1ps
module ccg_cpu_model (
    input wire logic mclk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic cpu_tick, // CPU clock enable
    input wire logic instr_tick, // Instruction boundary
    input wire logic ptap, // Fastest peripheral enable
    output logic [7:0] tick_gap, // Cycles between CPU ticks
    output logic [7:0] instr_gap, // Cycles between instruction ticks
    output logic [7:0] ptap_gap // Cycles between peripheral ticks
);
    logic [7:0] c_q [3];
    logic [7:0] g_q [3];
    logic [2:0] ev;
    assign ev = {ptap, instr_tick, cpu_tick};
    assign tick_gap = g_q[0];
    assign instr_gap = g_q[1];
    assign ptap_gap = g_q[2];
    always_ff @(posedge mclk or posedge reset) begin
        for (int i = 0; i < 3; i++) begin
            if (reset) begin
                c_q[i] <= 8'h01;
                g_q[i] <= 8'h00;
            end else if (ev[i]) begin
                g_q[i] <= c_q[i];
                c_q[i] <= 8'h01;
            end else begin
                c_q[i] <= c_q[i] + 8'h01;
            end
        end
    end
endmodule // ccg_cpu_model

// ### test/testbench.sv
// Self-checking bench for the CPU clock generator
`timescale 1ns/1ps
module testbench;
    logic mclk, reset, stop_req, halt_req, wake;
    ccg_pkg::ccg_bus_req_t req;
    logic [7:0] rdata_q, tick_gap, instr_gap, ptap_gap;
    logic cpu_reset_q, osc_run_q, cpu_tick_q, instr_tick_q, cpu_speed_q;
    logic [5:0] periph_tick_q;
    logic [1:0] standby_q;
    int bad_count = 0;
    int samples_checked = 0;
    int n, m;
    int pcnt [6];
    typedef struct {logic [1:0] op; logic [15:0] a; logic [7:0] d; logic [2:0] p;
        logic [7:0] e;} ccg_row_t;
    // Op 1 byte write, 2 bit write, 3 read of a; non-read rows read back fffb
    ccg_row_t rows [8] = '{
        '{2'h3, 16'hfffb, 8'h00, 3'h0, 8'h02},
        '{2'h1, 16'hfffb, 8'h00, 3'h0, 8'h00},
        '{2'h1, 16'hfffa, 8'h02, 3'h0, 8'h00},
        '{2'h2, 16'hfffb, 8'h01, 3'h1, 8'h02},
        '{2'h2, 16'hfffb, 8'h00, 3'h1, 8'h00},
        '{2'h2, 16'hfffa, 8'h01, 3'h1, 8'h00},
        '{2'h3, 16'hfffa, 8'h00, 3'h0, 8'h00},
        '{2'h1, 16'hfffb, 8'h02, 3'h0, 8'h02}};

    ccg_top #(.STAB_LOG2(3)) DUT (.mclk(mclk), .reset(reset), .bus_req(req),
        .stop_req(stop_req), .halt_req(halt_req), .wake(wake), .rdata_q(rdata_q),
        .cpu_reset_q(cpu_reset_q), .osc_run_q(osc_run_q), .cpu_tick_q(cpu_tick_q),
        .instr_tick_q(instr_tick_q), .cpu_speed_q(cpu_speed_q),
        .periph_tick_q(periph_tick_q), .standby_q(standby_q));
    ccg_cpu_model cpu (.mclk(mclk), .reset(reset), .cpu_tick(cpu_tick_q),
        .instr_tick(instr_tick_q), .ptap(periph_tick_q[0]), .tick_gap(tick_gap),
        .instr_gap(instr_gap), .ptap_gap(ptap_gap));

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(logic [1:0] op, logic [15:0] a, logic [7:0] d, logic [2:0] p);
        @(posedge mclk);
        req <= '{a, op == 2'h1, op == 2'h3, op == 2'h2, p, d};
        @(posedge mclk);
        req <= '{a, 1'b0, 1'b0, 1'b0, p, d};
        #1;
    endtask
    task automatic sw(logic [7:0] d, int lo, int hi);
        acc(2'h1, 16'hfffb, d, 3'h0);
        n = 0;
        while (cpu_speed_q !== d[1] && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("switch", 8'h01, n >= lo && n <= hi);
        repeat (20) @(posedge mclk);
        #1;
        chk("tick", d[1] ? 8'h04 : 8'h01, tick_gap);
        chk("instr", d[1] ? 8'h08 : 8'h02, instr_gap);
        chk("ptap", 8'h02, ptap_gap);
    endtask
    task automatic sb(logic s);
        @(posedge mclk);
        stop_req <= s;
        halt_req <= !s;
        @(posedge mclk);
        stop_req <= 1'b0;
        halt_req <= 1'b0;
        n = 0;
        m = 0;
        repeat (12) begin
            @(posedge mclk);
            #1;
            n += cpu_tick_q;
            m += (periph_tick_q != 6'h00);
        end
        chk("cpu_idle", 8'h00, n);
        chk("periph", s ? 8'h00 : 8'h01, m != 0);
        chk("standby", {s, !s}, standby_q);
        chk("osc", !s, osc_run_q);
        @(posedge mclk);
        wake <= 1'b1;
        n = 0;
        while (cpu_tick_q !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("resumed", 8'h01, cpu_tick_q);
        chk("awake", 8'h00, standby_q);
        @(posedge mclk);
        wake <= 1'b0;
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        stop_req = 1'b0;
        halt_req = 1'b0;
        wake = 1'b0;
        req = '0;
        repeat (6) @(posedge mclk);
        #1;
        chk("osc_rst", 8'h00, osc_run_q);
        chk("cpu_rst", 8'h01, cpu_reset_q);
        chk("spd_rst", 8'h01, cpu_speed_q);
        @(posedge mclk);
        reset <= 1'b0;
        n = 0;
        while (cpu_reset_q !== 1'b0 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("stab", 8'h01, n >= 8 && n <= 10);
        chk("osc_on", 8'h01, osc_run_q);
        sw(8'h02, 0, 1);
        for (int i = 0; i < 8; i++) begin
            if (rows[i].op != 2'h3) acc(rows[i].op, rows[i].a, rows[i].d, rows[i].p);
            acc(2'h3, rows[i].op == 2'h3 ? rows[i].a : 16'hfffb, 8'h00, 3'h0);
            chk("rdata", rows[i].e, rdata_q);
        end
        // Tap counts over 64 cycles; also lets the last speed change settle
        for (int i = 0; i < 6; i++) pcnt[i] = 0;
        repeat (64) begin
            @(posedge mclk);
            #1;
            for (int i = 0; i < 6; i++) pcnt[i] += periph_tick_q[i];
        end
        for (int i = 0; i < 6; i++) chk("ptap_n", 8'(64 >> (i + 1)), 8'(pcnt[i]));
        sw(8'h00, 2, 8);
        sw(8'h02, 2, 4);
        sb(1'b0);
        sb(1'b1);
        acc(2'h1, 16'hfffb, 8'h00, 3'h0);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk("osc_rst2", 8'h00, osc_run_q);
        chk("cpu_rst2", 8'h01, cpu_reset_q);
        chk("spd_rst2", 8'h01, cpu_speed_q);
        @(posedge mclk);
        reset <= 1'b0;
        acc(2'h3, 16'hfffb, 8'h00, 3'h0);
        chk("reg_rst2", 8'h02, rdata_q);
        conclude();
    end
endmodule // testbench
